// ==== rtl/timer_trio_consts.vh ====
/*
 Holds the register offsets, field positions, codes and masks of the three
 timers (lifetime, general, wake-up). Included by timer_trio.v, the checker and the bench.
*/
`ifndef TIMER_TRIO_CONSTS_VH
`define TIMER_TRIO_CONSTS_VH
// ==================================================
// Register byte addresses
`define ADDR_LIFE_RELOAD  32'hFFFF_0300
`define ADDR_LIFE_LOW     32'hFFFF_0304
`define ADDR_LIFE_HIGH    32'hFFFF_0308
`define ADDR_LIFE_CTRL    32'hFFFF_030C
`define ADDR_LIFE_REFRESH 32'hFFFF_0310
`define ADDR_LIFE_CAPT    32'hFFFF_0314
`define ADDR_GEN_RELOAD   32'hFFFF_0320
`define ADDR_GEN_COUNT    32'hFFFF_0324
`define ADDR_GEN_CTRL     32'hFFFF_0328
`define ADDR_GEN_REFRESH  32'hFFFF_032C
`define ADDR_GEN_CAPT     32'hFFFF_0330
`define ADDR_WAKE_RELOAD  32'hFFFF_0340
`define ADDR_WAKE_COUNT   32'hFFFF_0344
`define ADDR_WAKE_CTRL    32'hFFFF_0348
`define ADDR_WAKE_REFRESH 32'hFFFF_034C
`define ADDR_WAKE_CAPT    32'hFFFF_0350
// ==================================================
// Control field positions and writable masks
`define CTL_CAPEN   17
`define CTL_UP      8
`define CTL_EN      7
`define CTL_PER     6
`define CTL_MODE48  4
`define CTL_PS_WE   23
`define CTL_IRQSEL  18
`define MASK_LIFE   32'h0003_F7DF
`define MASK_GEN    19'h7_FFFF
`define MASK_WAKE   32'h0003_F7FF
// ==================================================
// Clock select codes
`define LSRC_OSC    2'h0
`define LSRC_PLL    2'h1
`define LSRC_XTAL   2'h2
`define LSRC_CORE   2'h3
`define GSRC_OSC    3'h0
`define GSRC_CORE   3'h1
`define GSRC_PLL    3'h2
`define GSRC_PIN    3'h3
`define WSRC_CORE   2'h0
`define WSRC_OSC    2'h1
`define WSRC_XTAL   2'h2
`define WSRC_PLL    2'h3
// ==================================================
// Prescaler codes and terminal counts
`define PRE_DIV16   4'h4
`define PRE_DIV256  4'h8
`define PRE_DIV32K  4'hF
`define PTC_DIV1    15'h0000
`define PTC_DIV16   15'h000F
`define PTC_DIV256  15'h00FF
`define PTC_DIV32K  15'h7FFF
// ==================================================
// Time format limits and highest event number
`define HOUR_LIM23  8'h17
`define HOUR_LIM255 8'hFF
`define MINSEC_MAX  6'h3B
`define TICK_MAX    7'h7F
`define EVT_MAX     5'h10
`endif

// ==== rtl/timer_trio.v ====
/*
 Three memory-mapped timers: lifetime (16/48 bit), general (32 bit with
 time format, postscaler, pin clock) and wake-up (32 bit), on Avalon-MM.
 Assumes all inputs synchronous to mclk; clock sources arrive as
 one-cycle tick enables; the pin clock counts on its rising edge.
*/
`include "timer_trio_consts.vh"

module timer_trio
(
    input  wire        mclk,          // Core clock, 250 MHz
    input  wire        rst_b,         // Asynchronous reset, active low
    input  wire [31:0] address,       // Avalon byte address
    input  wire        read,          // Avalon read request
    input  wire        write,         // Avalon write request
    input  wire [31:0] writedata,     // Avalon write data
    output reg  [31:0] readdata,      // Avalon read data
    output wire        waitrequest,   // Avalon wait
    input  wire        osc32Tick,     // Internal 32 kHz oscillator tick
    input  wire        xtal32Tick,    // External 32 kHz crystal tick
    input  wire        pllTick,       // Undivided PLL clock tick
    input  wire        timerClockPin, // General-purpose timer pin clock
    input  wire        lowPower,      // Part is in a low power mode
    input  wire        wakeIrqEnable, // Wake-up interrupt enable bit
    input  wire [16:0] irqSources,    // Interrupt sources, event 0..16
    output reg         lifetimeIrq,   // Lifetime timer interrupt
    output reg         generalIrq,    // General timer interrupt
    output reg         wakeupIrq      // Wake-up timer interrupt
);

// ==================================================
// Functions

// Terminal count of a prescaler code
function [14:0] preMask;
    input [3:0] code;
    begin
        case (code)
            `PRE_DIV16:  preMask = `PTC_DIV16;
            `PRE_DIV256: preMask = `PTC_DIV256;
            `PRE_DIV32K: preMask = `PTC_DIV32K;
            default:     preMask = `PTC_DIV1;
        endcase
    end
endfunction

// Rising edge of the selected event, numbers above 16 never hit
function evtHit;
    input [16:0] rise;
    input [4:0]  sel;
    begin
        evtHit = (sel <= `EVT_MAX) ? rise[sel] : 1'b0;
    end
endfunction

// One step of the hour:minute:second:tick format
function [31:0] hmsStep;
    input [31:0] v;
    input        up;
    input [7:0]  lim;
    reg   [7:0]  h;
    reg   [5:0]  m;
    reg   [5:0]  s;
    reg   [6:0]  f;
    begin
        h = v[31:24];
        m = v[21:16];
        s = v[13:8];
        f = v[6:0];
        if (up)
        begin
            f = (f == `TICK_MAX) ? 7'h00 : f + 7'h01;
            if (f == 7'h00)
                s = (s == `MINSEC_MAX) ? 6'h00 : s + 6'h01;
            if (f == 7'h00 && s == 6'h00)
                m = (m == `MINSEC_MAX) ? 6'h00 : m + 6'h01;
            if (f == 7'h00 && s == 6'h00 && m == 6'h00)
                h = (h == lim) ? 8'h00 : h + 8'h01;
        end
        else
        begin
            if (f == 7'h00 && s == 6'h00 && m == 6'h00)
                h = (h == 8'h00) ? lim : h - 8'h01;
            if (f == 7'h00 && s == 6'h00)
                m = (m == 6'h00) ? `MINSEC_MAX : m - 6'h01;
            if (f == 7'h00)
                s = (s == 6'h00) ? `MINSEC_MAX : s - 6'h01;
            f = (f == 7'h00) ? `TICK_MAX : f - 7'h01;
        end
        hmsStep = {h, 2'b00, m, 2'b00, s, 1'b0, f};
    end
endfunction

// Next count of a timer given its terminal state
function [31:0] nextCount;
    input [31:0] v;
    input        up;
    input        per;
    input [31:0] ld;
    input [31:0] full;
    input        term;
    input        hms;
    input [7:0]  lim;
    begin
        if (term)
            nextCount = per ? ld : (up ? 32'h0000_0000 : full);
        else if (hms)
            nextCount = hmsStep(v, up, lim);
        else
            nextCount = up ? v + 32'h0000_0001 : v - 32'h0000_0001;
    end
endfunction

// ==================================================
// Registers and state
reg  [15:0] lifeReload;   // Lifetime load value
reg  [31:0] lifeCtrl;     // Lifetime control
reg  [47:0] lifeCount;    // Lifetime counter
reg  [15:0] lifeCapt;     // Lifetime capture
reg  [31:0] genReload;    // General load value
reg  [18:0] genCtrl;      // General control, low field
reg  [7:0]  postScale;    // General postscaler compare value
reg  [7:0]  postCount;    // Overflows since last match
reg         postFlag;     // Postscaler compare flag
reg  [31:0] genCount;     // General counter
reg  [31:0] genCapt;      // General capture
reg  [31:0] wakeReload;   // Wake-up load value
reg  [31:0] wakeCtrl;     // Wake-up control
reg  [31:0] wakeCount;    // Wake-up counter
reg  [31:0] wakeCapt;     // Wake-up capture
reg  [16:0] srcPrev;      // Event sources, last cycle
reg         pinPrev;      // Pin clock, last cycle
reg         ack;          // Bus answer phase
reg  [31:0] rdMux;        // Read data selection
reg  [2:0]  srcTick;      // Selected source tick per timer
wire [2:0]  preTick;      // Prescaled tick per timer
wire [16:0] srcRise;      // Event first assertion
wire        pinEdge;      // Pin clock rising edge

assign srcRise = irqSources & ~srcPrev;
assign pinEdge = timerClockPin & ~pinPrev;

// ==================================================
// Avalon-MM slave: one wait cycle, then the answer
wire req      = read | write;
wire wrStb    = write & ack;
wire lifeClr  = wrStb & (address == `ADDR_LIFE_REFRESH);
wire genClr   = wrStb & (address == `ADDR_GEN_REFRESH);
wire wakeClr  = wrStb & (address == `ADDR_WAKE_REFRESH);

assign waitrequest = req & ~ack;

// Answer phase toggles for every request
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
        ack <= 1'b0;
    else
        ack <= req & ~ack;
end

// Read selection, unmapped reads return zero
always @*
begin
    case (address)
        `ADDR_LIFE_RELOAD: rdMux = {16'h0000, lifeReload};
        `ADDR_LIFE_LOW:    rdMux = {16'h0000, lifeCount[15:0]};
        `ADDR_LIFE_HIGH:   rdMux = lifeCount[47:16];
        `ADDR_LIFE_CTRL:   rdMux = lifeCtrl;
        `ADDR_LIFE_CAPT:   rdMux = {16'h0000, lifeCapt};
        `ADDR_GEN_RELOAD:  rdMux = genReload;
        `ADDR_GEN_COUNT:   rdMux = genCount;
        `ADDR_GEN_CTRL:    rdMux = {postScale, 4'h0, postFlag, genCtrl};
        `ADDR_GEN_CAPT:    rdMux = genCapt;
        `ADDR_WAKE_RELOAD: rdMux = wakeReload;
        `ADDR_WAKE_COUNT:  rdMux = wakeCount;
        `ADDR_WAKE_CTRL:   rdMux = wakeCtrl;
        `ADDR_WAKE_CAPT:   rdMux = wakeCapt;
        default:           rdMux = 32'h0000_0000;
    endcase
end

// Read data captured in the wait cycle; reads have no side effect
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
        readdata <= 32'h0000_0000;
    else if (read & ~ack)
        readdata <= rdMux;
end

// Software-written registers
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
    begin
        lifeReload <= 16'h0000;
        lifeCtrl   <= 32'h0000_0000;
        genReload  <= 32'h0000_0000;
        genCtrl    <= 19'h0_0000;
        postScale  <= 8'h00;
        wakeReload <= 32'h0000_0000;
        wakeCtrl   <= 32'h0000_0000;
    end
    else if (wrStb)
    begin
        case (address)
            `ADDR_LIFE_RELOAD: lifeReload <= writedata[15:0];
            `ADDR_LIFE_CTRL:   lifeCtrl   <= writedata & `MASK_LIFE;
            `ADDR_GEN_RELOAD:  genReload  <= writedata;
            `ADDR_GEN_CTRL:
            begin
                genCtrl <= writedata[18:0] & `MASK_GEN;
                if (writedata[`CTL_PS_WE])
                    postScale <= writedata[31:24];
            end
            `ADDR_WAKE_RELOAD: wakeReload <= writedata;
            `ADDR_WAKE_CTRL:   wakeCtrl   <= writedata & `MASK_WAKE;
            default:           lifeReload <= lifeReload;
        endcase
    end
end

// ==================================================
// Clock source selection
always @*
begin
    case (lifeCtrl[10:9])
        `LSRC_OSC:  srcTick[0] = osc32Tick;
        `LSRC_PLL:  srcTick[0] = pllTick;
        `LSRC_XTAL: srcTick[0] = xtal32Tick;
        default:    srcTick[0] = ~lowPower;    // Core clock stops in low power
    endcase
    case (genCtrl[11:9])
        `GSRC_OSC:  srcTick[1] = osc32Tick;
        `GSRC_CORE: srcTick[1] = ~lowPower;
        `GSRC_PLL:  srcTick[1] = pllTick & ~lowPower;
        `GSRC_PIN:  srcTick[1] = pinEdge;
        default:    srcTick[1] = 1'b0;
    endcase
    case (wakeCtrl[10:9])
        `WSRC_CORE: srcTick[2] = 1'b1;
        `WSRC_OSC:  srcTick[2] = osc32Tick;
        `WSRC_XTAL: srcTick[2] = xtal32Tick;
        default:    srcTick[2] = pllTick;
    endcase
end

// ==================================================
// Prescalers, one per timer
wire [2:0]  tmrEn    = {wakeCtrl[`CTL_EN], genCtrl[`CTL_EN], lifeCtrl[`CTL_EN]};
wire [11:0] preField = {wakeCtrl[3:0], genCtrl[3:0], lifeCtrl[3:0]};

genvar g;
generate
    for (g = 0; g < 3; g = g + 1)
    begin : gPre
        reg [14:0] preCnt;  // Source ticks since last prescaled tick
        wire       preEnd = (preCnt >= preMask(preField[4*g+3 -: 4])); // Stale count ends at once

        // Counts source ticks while the timer is enabled
        always @(posedge mclk or negedge rst_b)
        begin
            if (!rst_b)
                preCnt <= 15'h0000;
            else if (!tmrEn[g])
                preCnt <= 15'h0000;
            else if (srcTick[g])
                preCnt <= preEnd ? 15'h0000 : preCnt + 15'h0001;
        end
        assign preTick[g] = tmrEn[g] & srcTick[g] & preEnd;
    end
endgenerate

// Event edge and pin history
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
    begin
        srcPrev <= 17'h0_0000;
        pinPrev <= 1'b0;
    end
    else
    begin
        srcPrev <= irqSources;
        pinPrev <= timerClockPin;
    end
end

// ==================================================
// Lifetime timer
wire        lifeWide = lifeCtrl[`CTL_MODE48];
wire        lifeUp   = lifeCtrl[`CTL_UP];
wire        lifeTerm = lifeWide ? (&lifeCount)
                     : (lifeUp ? (lifeCount[15:0] == 16'hFFFF)
                               : (lifeCount[15:0] == 16'h0000));
wire [31:0] lifeNext = nextCount({16'h0000, lifeCount[15:0]}, lifeUp,
                                 lifeCtrl[`CTL_PER], {16'h0000, lifeReload},
                                 32'h0000_FFFF, lifeTerm, 1'b0, 8'h00);
wire        lifeOv   = preTick[0] & lifeTerm;

// Counter, capture and interrupt
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
    begin
        lifeCount   <= 48'h0000_0000_0000;
        lifeCapt    <= 16'h0000;
        lifetimeIrq <= 1'b0;
    end
    else
    begin
        if (lifeClr)
            lifeCount <= lifeWide ? 48'h0000_0000_0000
                                  : {32'h0000_0000, lifeReload};
        else if (preTick[0] && lifeWide)
            lifeCount <= lifeCount + 48'h0000_0000_0001;
        else if (preTick[0])
            lifeCount <= {32'h0000_0000, lifeNext[15:0]};
        if (lifeCtrl[`CTL_CAPEN] && !lifeWide && evtHit(srcRise, lifeCtrl[16:12]))
            lifeCapt <= lifeCount[15:0];
        lifetimeIrq <= lifeOv | (lifetimeIrq & ~lifeClr);
    end
end

// ==================================================
// General timer
wire        genUp    = genCtrl[`CTL_UP];
wire        genHms   = genCtrl[5];
wire [7:0]  genLim   = genCtrl[4] ? `HOUR_LIM255 : `HOUR_LIM23;
wire [31:0] genFull  = genHms ? {genLim, 2'b00, `MINSEC_MAX, 2'b00,
                                 `MINSEC_MAX, 1'b0, `TICK_MAX} : 32'hFFFF_FFFF;
wire        genTerm  = genUp ? (genCount == genFull) : (genCount == 32'h0000_0000);
wire        genOv    = preTick[1] & genTerm;
wire        postHit  = genOv & (postCount == postScale);

// Counter, postscaler, capture and interrupt
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
    begin
        genCount   <= 32'h0000_0000;
        genCapt    <= 32'h0000_0000;
        postCount  <= 8'h00;
        postFlag   <= 1'b0;
        generalIrq <= 1'b0;
    end
    else
    begin
        if (genClr)
            genCount <= genReload;
        else if (preTick[1])
            genCount <= nextCount(genCount, genUp, genCtrl[`CTL_PER],
                                  genReload, genFull, genTerm,
                                  genHms, genLim);
        if (genClr || postHit)
            postCount <= 8'h00;
        else if (genOv)
            postCount <= postCount + 8'h01;
        postFlag <= postHit | (postFlag & ~genClr);
        if (genCtrl[`CTL_CAPEN] && evtHit(srcRise, genCtrl[16:12]))
            genCapt <= genCount;
        generalIrq <= (genCtrl[`CTL_IRQSEL] ? postHit : genOv)
                    | (generalIrq & ~genClr);
    end
end

// ==================================================
// Wake-up timer
wire        wakeUp   = wakeCtrl[`CTL_UP];
wire        wakeHms  = wakeCtrl[5];
wire [7:0]  wakeLim  = wakeCtrl[4] ? `HOUR_LIM255 : `HOUR_LIM23;
wire [31:0] wakeFull = wakeHms ? {wakeLim, 2'b00, `MINSEC_MAX, 2'b00,
                                  `MINSEC_MAX, 1'b0, `TICK_MAX} : 32'hFFFF_FFFF;
wire        wakeTerm = wakeUp ? (wakeCount == wakeFull) : (wakeCount == 32'h0000_0000);

// Counter, capture and interrupt
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
    begin
        wakeCount <= 32'h0000_0000;
        wakeCapt  <= 32'h0000_0000;
        wakeupIrq <= 1'b0;
    end
    else
    begin
        if (wakeClr)
            wakeCount <= wakeReload;
        else if (preTick[2])
            wakeCount <= nextCount(wakeCount, wakeUp, wakeCtrl[`CTL_PER],
                                   wakeReload, wakeFull, wakeTerm,
                                   wakeHms, wakeLim);
        if (wakeIrqEnable && wakeCtrl[`CTL_CAPEN]
            && evtHit(srcRise, wakeCtrl[16:12]))
            wakeCapt <= wakeCount;
        wakeupIrq <= (preTick[2] & wakeTerm) | (wakeupIrq & ~wakeClr);
    end
end

endmodule // timer_trio

// ==== verif/timer_trio_props.sv ====
/* Checker for timer_trio: bus handshake, read data and interrupt relations.
   Assumes it sees only top module ports; the bind stands at the foot. */
`include "timer_trio_consts.vh"
module timer_trio_props
(
    input logic        mclk,        // Core clock
    input logic        rst_b,       // Reset, active low
    input logic [31:0] address,     // Byte address
    input logic        read,        // Read request
    input logic        write,       // Write request
    input logic [31:0] writedata,   // Write data
    input logic [31:0] readdata,    // Read data
    input logic        waitrequest, // Bus wait
    input logic        lifetimeIrq, // Lifetime interrupt
    input logic        generalIrq,  // General interrupt
    input logic        wakeupIrq    // Wake-up interrupt
);
    // ==================================================
    // Shadow enables; a timer counts as quiet two cycles after disable
    logic       acc;                      // Write accepted at this edge
    logic [2:0] en, enQ, enQQ, off, clr;  // Enables, delays, quiet timers, refreshes
    assign acc = write && !waitrequest;
    assign off = ~(en | enQ | enQQ);
    assign clr = {3{acc}} & {address == `ADDR_WAKE_REFRESH,
                 address == `ADDR_GEN_REFRESH, address == `ADDR_LIFE_REFRESH};
    // Track control writes of the enable bit
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en   <= 3'h0;
            enQ  <= 3'h0;
            enQQ <= 3'h0;
        end
        else
        begin
            if (acc && address == `ADDR_LIFE_CTRL) en[0] <= writedata[7];
            if (acc && address == `ADDR_GEN_CTRL) en[1] <= writedata[7];
            if (acc && address == `ADDR_WAKE_CTRL) en[2] <= writedata[7];
            enQ  <= en;
            enQQ <= enQ;
        end
    end
    // ==================================================
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    AST_IDLE_NO_WAIT: assert property (!(read || write) |-> !waitrequest)
        else $error("wait raised while idle");
    AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request held longer than one wait cycle");
    AST_RDATA_HOLD: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("read data moved without a read");
    AST_WO_READ_ZERO: assert property (read && !waitrequest && (address ==
        `ADDR_LIFE_REFRESH || address == `ADDR_GEN_REFRESH) |-> readdata == 32'h0000_0000)
        else $error("refresh register read nonzero");
    AST_LIFE_CLR: assert property (clr[0] && off[0] |=> !lifetimeIrq)
        else $error("lifetime refresh left interrupt set");
    AST_GEN_CLR: assert property (clr[1] && off[1] |=> !generalIrq)
        else $error("general refresh left interrupt set");
    AST_WAKE_CLR: assert property (clr[2] && off[2] |=> !wakeupIrq)
        else $error("wake-up refresh left interrupt set");
    AST_GEN_STICKY: assert property (generalIrq && !clr[1] |=> generalIrq)
        else $error("general interrupt dropped without refresh");
    AST_GEN_QUIET: assert property (off[1] && !generalIrq |=> !generalIrq)
        else $error("disabled general timer raised interrupt");
    cover property (clr[1] && generalIrq);
    cover property ($rose(generalIrq));
    cover property ($rose(wakeupIrq));
endmodule // timer_trio_props

bind timer_trio timer_trio_props i_timer_trio_props (.mclk(mclk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .lifetimeIrq(lifetimeIrq),
    .generalIrq(generalIrq), .wakeupIrq(wakeupIrq));

// ==== verif/tb_top.sv ====
/* Self-checking bench for timer_trio: bus tasks, tick pulses, scenarios.
   Assumes the design header and the checker are compiled alongside. */
`include "timer_trio_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================
    // Design connections, inputs given values at time zero
    logic        mclk = 1'b0, rst_b = 1'b0;                // Clock, reset
    logic        read = 1'b0, write = 1'b0;                // Bus requests
    logic [31:0] address = 32'h0000_0000, writedata = 32'h0000_0000;
    logic [31:0] readdata;                                 // Bus read data
    logic        waitrequest, lifetimeIrq, generalIrq, wakeupIrq;
    logic        osc32Tick = 1'b0, xtal32Tick = 1'b0, pllTick = 1'b0;
    logic        timerClockPin = 1'b0, lowPower = 1'b0, wakeIrqEnable = 1'b0;
    logic [16:0] irqSources = 17'h0_0000;                  // Event lines
    int          err_total = 0, n_checks = 0, seed = 89, cyc = 0;
    int          e, k;                                     // Event, ticks
    logic [31:0] ld, ctl;                                  // Reload, control
    // Register addresses per timer: lifetime, general, wake-up
    logic [31:0] ldA [3] = '{`ADDR_LIFE_RELOAD, `ADDR_GEN_RELOAD, `ADDR_WAKE_RELOAD};
    logic [31:0] ctA [3] = '{`ADDR_LIFE_CTRL, `ADDR_GEN_CTRL, `ADDR_WAKE_CTRL};
    logic [31:0] rfA [3] = '{`ADDR_LIFE_REFRESH, `ADDR_GEN_REFRESH, `ADDR_WAKE_REFRESH};
    logic [31:0] vaA [3] = '{`ADDR_LIFE_LOW, `ADDR_GEN_COUNT, `ADDR_WAKE_COUNT};
    logic [31:0] cpA [3] = '{`ADDR_LIFE_CAPT, `ADDR_GEN_CAPT, `ADDR_WAKE_CAPT};

    timer_trio i_timer_trio (.mclk(mclk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .osc32Tick(osc32Tick), .xtal32Tick(xtal32Tick), .pllTick(pllTick),
        .timerClockPin(timerClockPin), .lowPower(lowPower), .wakeIrqEnable(wakeIrqEnable),
        .irqSources(irqSources), .lifetimeIrq(lifetimeIrq), .generalIrq(generalIrq),
        .wakeupIrq(wakeupIrq));

    // ==================================================
    // Clock and hang guard
    always #2 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            err_total++;
            final_report();
        end
    end
    // ==================================================
    // Tasks and expectation function
    function automatic logic [31:0] after(input logic [31:0] v, input int n, input logic up);
        return up ? v + n : v - n;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Bus cycles hold the request until waitrequest is seen low
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        @(posedge mclk);
        address <= a;
        read <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        check(readdata, exp);
    endtask
    // Pulse sources {osc, pll, xtal, pin} n times, then settle
    task automatic tick(input logic [3:0] m, input int n);
        repeat (n)
        begin
            @(posedge mclk);
            {osc32Tick, pllTick, xtal32Tick, timerClockPin} <= m;
            @(posedge mclk);
            {osc32Tick, pllTick, xtal32Tick, timerClockPin} <= 4'h0;
        end
        repeat (3) @(posedge mclk);
    endtask
    task automatic cfg(input int t, input logic [31:0] c, input logic [31:0] v);
        wr(ldA[t], v);
        wr(ctA[t], c);
        wr(rfA[t], 32'h0000_00A5);
    endtask
    task automatic evt(input int n);
        @(posedge mclk);
        irqSources <= 17'h0_0001 << n;
        repeat (3) @(posedge mclk);
        irqSources <= 17'h0_0000;
    endtask
    // Interrupt t (0 lifetime, 1 general, 2 wake-up) sampled one edge later
    task automatic irq_is(input int t, input logic exp);
        @(posedge mclk);
        check(32'({wakeupIrq, generalIrq, lifetimeIrq} >> t) & 32'h0000_0001, 32'(exp));
    endtask
    task final_report;
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==================================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        for (int t = 0; t < 3; t++)
        begin
            rc(ldA[t], 0);
            rc(ctA[t], 0);
            rc(vaA[t], 0);
            rc(cpA[t], 0);
            rc(rfA[t], 0);
        end
        rc(`ADDR_LIFE_HIGH, 0);
        rc(32'hFFFF_0318, 0);
        wr(`ADDR_GEN_COUNT, $random(seed));
        rc(`ADDR_GEN_COUNT, 0);
        ctl = $random(seed);
        wr(`ADDR_LIFE_CTRL, ctl);
        rc(`ADDR_LIFE_CTRL, ctl & `MASK_LIFE);
        // General: wrong sources ignored, postscaler of 1, periodic, refresh clears
        cfg(1, 32'h0184_00C0, 1);
        tick(4'b0111, 2);
        rc(`ADDR_GEN_COUNT, 1);
        tick(4'b1000, 2);
        irq_is(1, 1'b0);
        tick(4'b1000, 2);
        rc(`ADDR_GEN_COUNT, 1);
        rc(`ADDR_GEN_CTRL, 32'h010C_00C0);
        irq_is(1, 1'b1);
        wr(`ADDR_GEN_CTRL, 0);
        wr(`ADDR_GEN_REFRESH, $random(seed));
        irq_is(1, 1'b0);
        cfg(1, 32'h0000_0080, 0);
        tick(4'b1000, 1);
        rc(`ADDR_GEN_COUNT, 32'hFFFF_FFFF);
        cfg(1, 32'h0000_01C0, 32'hFFFF_FFFE);
        tick(4'b1000, 2);
        rc(`ADDR_GEN_COUNT, 32'hFFFF_FFFE);
        repeat (4)
        begin
            ld = 32'($unsigned($random(seed)) % 65536 + 300);
            k = $unsigned($random(seed)) % 200;
            cfg(1, 32'h0000_00C0, ld);
            tick(4'b1000, k);
            rc(`ADDR_GEN_COUNT, after(ld, k, 1'b0));
        end
        // Prescaler codes on ticked and core sources
        for (int i = 0; i < 3; i++)
        begin
            cfg(1, 32'h0000_00C0 | 32'(4 * i), 1000);
            tick(4'b1000, i == 0 ? 5 : i == 1 ? 32 : 256);
            rc(`ADDR_GEN_COUNT, after(1000, i == 0 ? 5 : 3 - i, 1'b0));
        end
        cfg(1, 32'h0000_02CF, 1000);
        repeat (40000) @(posedge mclk);
        rc(`ADDR_GEN_COUNT, 999);
        // Low power: pin source runs on, core source stops
        lowPower <= 1'b1;
        cfg(1, 32'h0000_06C0, 50);
        tick(4'b0001, 3);
        rc(`ADDR_GEN_COUNT, 47);
        cfg(1, 32'h0000_02C0, 50);
        repeat (20) @(posedge mclk);
        rc(`ADDR_GEN_COUNT, 50);
        lowPower <= 1'b0;
        // Formats: time of day carries, reserved code counts binary
        for (int i = 0; i < 4; i++)
        begin
            cfg(1, 32'h0000_01C0 | 32'((i + 2) & 3) << 4, i == 1 ? 32'h173B_3B7F : 32'h7F);
            tick(4'b1000, 1);
            rc(`ADDR_GEN_COUNT, i == 0 ? 32'h0000_0100 : i == 1 ? 32'h1800_0000 : 32'h80);
        end
        // Capture on a random event while counting continues
        e = $unsigned($random(seed)) % 17;
        cfg(1, 32'h0002_00C0 | 32'(e) << 12, 77);
        evt(e);
        tick(4'b1000, 1);
        rc(`ADDR_GEN_CAPT, 77);
        rc(`ADDR_GEN_COUNT, 76);
        // Lifetime: source select, direction, capture, 48-bit, refresh
        for (int c = 0; c < 3; c++)
        begin
            cfg(0, 32'(c) << 9 | 32'(c & 1) << 8 | 32'h0000_00C0, 100);
            tick(4'b1000 >> c, 3);
            rc(`ADDR_LIFE_LOW, after(100, 3, c[0]));
        end
        cfg(0, 32'h0002_00C0 | 32'(e) << 12, 500);
        evt(e);
        rc(`ADDR_LIFE_CAPT, 500);
        cfg(0, 32'h0002_00D0 | 32'(e) << 12, 500);
        evt(e);
        tick(4'b1000, 5);
        rc(`ADDR_LIFE_CAPT, 500);
        rc(`ADDR_LIFE_LOW, 5);
        rc(`ADDR_LIFE_HIGH, 0);
        cfg(0, 32'h0000_00C0, 1);
        tick(4'b1000, 2);
        irq_is(0, 1'b1);
        wr(`ADDR_LIFE_CTRL, 0);
        wr(`ADDR_LIFE_REFRESH, 0);
        irq_is(0, 1'b0);
        // Wake-up: runs in low power, capture gated by interrupt enable
        lowPower <= 1'b1;
        cfg(2, 32'h0002_02C0 | 32'(e) << 12, 2);
        tick(4'b1000, 3);
        rc(`ADDR_WAKE_COUNT, 2);
        irq_is(2, 1'b1);
        evt(e);
        rc(`ADDR_WAKE_CAPT, 0);
        wakeIrqEnable <= 1'b1;
        evt(e);
        rc(`ADDR_WAKE_CAPT, 2);
        wr(`ADDR_WAKE_CTRL, 0);
        wr(`ADDR_WAKE_REFRESH, 32'h0000_00FF);
        irq_is(2, 1'b0);
        final_report();
    end
endmodule // tb_top
